// [design/tstc_top.sv]
/*
 Two-stage preset timer core: power-up handling, switch latching, digit entry,
 compare outputs and self-diagnostic fault states.
 Assumes key inputs are single-cycle press pulses and fault detectors drive level flags.
*/
`timescale 1ns/100ps
`default_nettype none
module tstc_top #(
   parameter int LONG_CYC = tstc_pkg::WIDTH_LONG_CYC,
   parameter int SHORT_CYC = tstc_pkg::WIDTH_SHORT_CYC,
   parameter int TICK_CYC = tstc_pkg::TICK_CYC
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic i_START,
   input wire logic i_RESET_A,
   input wire logic i_RESET_B,
   input wire logic i_GATE,
   input wire logic [7:1] i_SWITCH,
   input wire logic i_KEY_RESET_HELD,
   input wire logic i_KEY_DIGIT4_HELD,
   input wire logic i_KEY_RESET,
   input wire logic [3:0] i_KEY_DIGIT,
   input wire logic i_KEY_SET_SEL,
   input wire logic i_KEY_METHOD,
   input wire logic i_METHOD_STORED,
   input wire logic i_NV_VALID,
   input wire logic i_FAULT_CPU,
   input wire logic i_FAULT_RAM,
   input wire logic i_FAULT_NV,
   output logic o_FIRST_OUTPUT,
   output logic o_SECOND_OUTPUT,
   output logic o_RESET_LAMP,
   output logic [1:0] o_FAULT_CODE,
   output logic o_CHECKSUM_IND,
   output logic o_METHOD_ABS,
   output logic o_METHOD_NEW,
   output logic o_METHOD_WRITE,
   output logic [15:0] o_PRESENT,
   output logic [15:0] o_SET1,
   output logic [15:0] o_SET2,
   output logic [1:0] o_TIME_RANGE,
   output logic o_MODE_A,
   output logic o_POLARITY_PNP,
   output logic o_STATE_SELECT
);
   localparam int TW = $clog2(TICK_CYC + 1);

   tstc_pkg::tstc_state_t state_q;
   logic [6:0] sw_q;
   logic method_q;
   logic sel_method_q;
   logic [15:0] set1_q;
   logic [15:0] set2_q;
   logic [15:0] pv_q;
   logic [TW-1:0] tick_q;
   logic running_q;
   logic start_prev_q;
   logic [1:0] code_q;
   logic sum_q;
   logic first_q;
   logic second_q;
   logic start_f;
   logic rst_a_f;
   logic rst_b_f;
   logic gate_f;
   logic rst_in;
   logic tick;
   logic first_hit;
   logic second_hit;
   logic [15:0] fc_target;
   logic fault_any;

   // Digit-wise BCD increment, wraps 9 back to 0
   function automatic logic [15:0] digit_step(input logic [15:0] v, input logic [3:0] k);
      logic [15:0] r;
      r = v;
      for (int i = 0; i < tstc_pkg::DIGITS; i++) begin
         if (k[i]) begin
            r[i*4 +: 4] = (v[i*4 +: 4] >= tstc_pkg::DIGIT_MAX) ? 4'h0 : v[i*4 +: 4] + 4'h1;
         end
      end
      return r;
   endfunction : digit_step

   // BCD to binary so forecast arithmetic works on plain counts
   function automatic logic [15:0] bcd_bin(input logic [15:0] v);
      logic [15:0] r;
      r = 16'(v[15:12]) * 16'h03E8 + 16'(v[11:8]) * 16'h0064 + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
      return r;
   endfunction : bcd_bin

   logic short_w;
   logic pol_w;
   assign short_w = sw_q[tstc_pkg::SW_SHORT];
   assign pol_w = sw_q[tstc_pkg::SW_POLARITY];

   // Polarity folded in before filtering, so the width always applies to the active level
   tstc_filter #(
      .LONG_CYC(LONG_CYC),
      .SHORT_CYC(SHORT_CYC)
   ) u_f_start (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_short(short_w),
      .i_raw(i_START ^ pol_w),
      .o_level(start_f)
   );
   tstc_filter #(
      .LONG_CYC(LONG_CYC),
      .SHORT_CYC(SHORT_CYC)
   ) u_f_rsta (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_short(short_w),
      .i_raw(i_RESET_A ^ pol_w),
      .o_level(rst_a_f)
   );
   tstc_filter #(
      .LONG_CYC(LONG_CYC),
      .SHORT_CYC(SHORT_CYC)
   ) u_f_rstb (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_short(short_w),
      .i_raw(i_RESET_B ^ pol_w),
      .o_level(rst_b_f)
   );
   tstc_filter #(
      .LONG_CYC(LONG_CYC),
      .SHORT_CYC(SHORT_CYC)
   ) u_f_gate (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_short(short_w),
      .i_raw(i_GATE ^ pol_w),
      .o_level(gate_f)
   );

   assign rst_in = rst_a_f | rst_b_f;
   assign fault_any = i_FAULT_CPU | i_FAULT_RAM | i_FAULT_NV;

   // Power-up phase: the cycle after reset release latches switches and strap keys
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         state_q <= tstc_pkg::ST_POWERUP;
      end else begin
         unique case (state_q)
            tstc_pkg::ST_POWERUP: begin
               if (i_KEY_RESET_HELD && i_KEY_DIGIT4_HELD) begin
                  state_q <= tstc_pkg::ST_SELECT;
               end else begin
                  state_q <= tstc_pkg::ST_RUN;
               end
            end
            tstc_pkg::ST_SELECT: begin
               state_q <= tstc_pkg::ST_SELECT;
            end
            tstc_pkg::ST_RUN: begin
               if (fault_any) begin
                  state_q <= tstc_pkg::ST_FAULT;
               end
            end
            tstc_pkg::ST_FAULT: begin
               if (i_KEY_RESET && code_q == tstc_pkg::ERR_PROC && !i_FAULT_CPU) begin
                  state_q <= tstc_pkg::ST_RUN;
               end else if (i_KEY_RESET && sum_q) begin
                  state_q <= tstc_pkg::ST_RUN;
               end
               // Working-memory fault has no exit short of a power cycle
            end
            default: state_q <= tstc_pkg::ST_POWERUP;
         endcase
      end
   end

   // Switches caught once at power-up; later changes ignored until next power-up
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         sw_q <= 7'h00;
      end else if (state_q == tstc_pkg::ST_POWERUP) begin
         sw_q <= i_SWITCH;
      end
   end

   // Stored method: forecast unless nonvolatile copy is valid and says absolute
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         method_q <= tstc_pkg::METHOD_RESET[0];
      end else if (state_q == tstc_pkg::ST_POWERUP) begin
         method_q <= i_NV_VALID & i_METHOD_STORED;
      end else if (state_q == tstc_pkg::ST_FAULT && sum_q && i_KEY_RESET) begin
         method_q <= tstc_pkg::METHOD_RESET[0];
      end
   end

   // Selection toggles a candidate; storing it only takes effect at the next power-up
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         sel_method_q <= 1'b0;
         o_METHOD_WRITE <= 1'b0;
      end else begin
         o_METHOD_WRITE <= 1'b0;
         if (state_q == tstc_pkg::ST_POWERUP) begin
            sel_method_q <= i_NV_VALID & i_METHOD_STORED;
         end else if (state_q == tstc_pkg::ST_SELECT && i_KEY_METHOD) begin
            sel_method_q <= ~sel_method_q;
            o_METHOD_WRITE <= 1'b1;
         end
      end
   end

   // Set values: digit keys in run, cleared on method change or factory restore
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         set1_q <= 16'h0000;
         set2_q <= 16'h0000;
      end else if (state_q == tstc_pkg::ST_SELECT && i_KEY_METHOD) begin
         set1_q <= 16'h0000;
         set2_q <= 16'h0000;
      end else if (state_q == tstc_pkg::ST_FAULT && sum_q && i_KEY_RESET) begin
         set1_q <= 16'h0000;
         set2_q <= 16'h0000;
      end else if (state_q == tstc_pkg::ST_RUN && !sw_q[tstc_pkg::SW_UP_LOCK]) begin
         if (i_KEY_SET_SEL) begin
            set2_q <= digit_step(set2_q, i_KEY_DIGIT);
         end else begin
            set1_q <= digit_step(set1_q, i_KEY_DIGIT);
         end
      end
   end

   // Time base: one tick per resolution period
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST || !running_q || rst_in) begin
         tick_q <= '0;
      end else if (tick) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + TW'(1);
      end
   end
   assign tick = running_q && (tick_q == TW'(TICK_CYC - 1));

   // Start edge arms timing; reset input, selection and faults halt it
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         running_q <= 1'b0;
         start_prev_q <= 1'b0;
      end else begin
         start_prev_q <= start_f;
         if (state_q != tstc_pkg::ST_RUN || rst_in) begin
            running_q <= 1'b0;
         end else if (start_f && !start_prev_q) begin
            running_q <= 1'b1;
         end
      end
   end

   // Present value; count saturates rather than wrapping past the top
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         pv_q <= 16'h0000;
      end else if (rst_in || (state_q == tstc_pkg::ST_RUN && i_KEY_RESET && !sw_q[tstc_pkg::SW_RST_LOCK])) begin
         pv_q <= 16'h0000;
      end else if (state_q == tstc_pkg::ST_SELECT && i_KEY_METHOD) begin
         pv_q <= 16'h0000;
      end else if (tick && !gate_f && pv_q != 16'hFFFF) begin
         pv_q <= pv_q + 16'h0001;
      end
   end

   // Compare targets: set1 carries the forecast offset in forecast method
   assign fc_target = bcd_bin(set2_q) - bcd_bin(set1_q);
   always_comb begin
      if (method_q) begin
         first_hit = pv_q >= bcd_bin(set1_q);
         second_hit = pv_q >= bcd_bin(set2_q);
      end else begin
         if (bcd_bin(set1_q) >= bcd_bin(set2_q)) begin
            first_hit = 1'b1;
         end else begin
            first_hit = pv_q >= fc_target;
         end
         second_hit = pv_q >= bcd_bin(set2_q);
      end
   end

   // Outputs only after a start; every non-run state and reset input forces them off
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         first_q <= 1'b0;
         second_q <= 1'b0;
      end else if (state_q != tstc_pkg::ST_RUN || fault_any) begin
         first_q <= 1'b0;
         second_q <= 1'b0;
      end else if (rst_in) begin
         first_q <= 1'b0;
         second_q <= 1'b0;
      end else if (running_q) begin
         first_q <= first_hit;
         second_q <= second_hit;
      end
   end

   // Fault code; checksum flag marks the nonvolatile case
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         code_q <= tstc_pkg::ERR_NONE;
         sum_q <= 1'b0;
      end else if (state_q == tstc_pkg::ST_RUN && fault_any) begin
         if (i_FAULT_RAM) begin
            code_q <= tstc_pkg::ERR_MEM;
            sum_q <= 1'b0;
         end else if (i_FAULT_NV) begin
            code_q <= tstc_pkg::ERR_MEM;
            sum_q <= 1'b1;
         end else begin
            code_q <= tstc_pkg::ERR_PROC;
            sum_q <= 1'b0;
         end
      end else if (state_q == tstc_pkg::ST_FAULT && i_KEY_RESET && code_q == tstc_pkg::ERR_PROC && !i_FAULT_CPU) begin
         code_q <= tstc_pkg::ERR_NONE;
      end else if (state_q == tstc_pkg::ST_FAULT && i_KEY_RESET && sum_q) begin
         code_q <= tstc_pkg::ERR_NONE;
         sum_q <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         o_RESET_LAMP <= 1'b0;
      end else begin
         o_RESET_LAMP <= rst_in;
      end
   end

   assign o_FIRST_OUTPUT = first_q;
   assign o_SECOND_OUTPUT = second_q;
   assign o_FAULT_CODE = code_q;
   assign o_CHECKSUM_IND = sum_q;
   assign o_METHOD_ABS = method_q;
   assign o_METHOD_NEW = sel_method_q;
   assign o_PRESENT = pv_q;
   assign o_SET1 = set1_q;
   assign o_SET2 = set2_q;
   assign o_TIME_RANGE = sw_q[1:0];
   assign o_MODE_A = sw_q[tstc_pkg::SW_MODE_A];
   assign o_POLARITY_PNP = pol_w;
   assign o_STATE_SELECT = (state_q == tstc_pkg::ST_SELECT);
endmodule : tstc_top
`default_nettype wire

// [shared/tstc_pkg.sv]
/*
 Package for the two-stage preset timer core: constants, timing figures and state encodings.
 Assumes a single 10 MHz clock and a synchronous active-high power-up reset.
*/
package tstc_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int WIDTH_LONG_MS = 20;
   localparam int WIDTH_SHORT_MS = 1;
   localparam int WIDTH_LONG_CYC = (CLK_HZ / 1000) * WIDTH_LONG_MS;
   localparam int WIDTH_SHORT_CYC = (CLK_HZ / 1000) * WIDTH_SHORT_MS;
   localparam int TICK_RES_MS = 1;
   localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_RES_MS;
   localparam int DIGITS = 4;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   // Bit positions inside the latched switch word; switch n sits at bit n-1
   localparam int SW_MODE_A = 2;
   localparam int SW_SHORT = 3;
   localparam int SW_POLARITY = 4;
   localparam int SW_RST_LOCK = 5;
   localparam int SW_UP_LOCK = 6;
   localparam logic [1:0] METHOD_RESET = 2'h0;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_PROC = 2'h1;
   localparam logic [1:0] ERR_MEM = 2'h2;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_SELECT = 4'h2,
      ST_FAULT = 4'h4,
      ST_POWERUP = 4'h8
   } tstc_state_t;
endpackage : tstc_pkg

// [design/tstc_filter.sv]
/*
 Input width filter: passes a level only after it has held for the selected width.
 Assumes the input is synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tstc_filter #(
   parameter int LONG_CYC = tstc_pkg::WIDTH_LONG_CYC,
   parameter int SHORT_CYC = tstc_pkg::WIDTH_SHORT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_short,
   input wire logic i_raw,
   output logic o_level
);
   localparam int CW = $clog2(LONG_CYC + 1);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] lim;
   assign lim = i_short ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
   // Change accepted only once stable for full width; glitches restart the count
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= '0;
         o_level <= 1'b0;
      end else if (i_raw == o_level) begin
         cnt_q <= '0;
      end else if (cnt_q >= lim) begin
         cnt_q <= '0;
         o_level <= i_raw;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
endmodule : tstc_filter
`default_nettype wire

// [test/tstc_checker_properties.sv]
/*
 Port-level checker for the two-stage timer core.
 Bound to tstc_top below; sees only its ports, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module tstc_checker #(
   parameter int LONG_CYC = tstc_pkg::WIDTH_LONG_CYC,
   parameter int SHORT_CYC = tstc_pkg::WIDTH_SHORT_CYC,
   parameter int TICK_CYC = tstc_pkg::TICK_CYC
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic o_FIRST_OUTPUT,
   input wire logic o_SECOND_OUTPUT,
   input wire logic o_RESET_LAMP,
   input wire logic [1:0] o_FAULT_CODE,
   input wire logic o_METHOD_ABS,
   input wire logic o_METHOD_WRITE,
   input wire logic [15:0] o_PRESENT,
   input wire logic [15:0] o_SET1,
   input wire logic [15:0] o_SET2,
   input wire logic o_MODE_A,
   input wire logic o_STATE_SELECT
);
   function automatic logic [15:0] b2n(input logic [15:0] b);
      return 16'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
   endfunction : b2n
   logic [15:0] s1;
   logic [15:0] s2;
   logic [15:0] t1;
   logic [15:0] pv_q;
   int gap_q;
   assign s1 = b2n(o_SET1);
   assign s2 = b2n(o_SET2);
   // Offset not below the set value puts the first target at zero
   assign t1 = o_METHOD_ABS ? s1 : ((s1 >= s2) ? 16'h0 : s2 - s1);
   always_ff @(posedge I_CLK) begin
      pv_q <= o_PRESENT;
      gap_q <= (I_SYS_RST || o_PRESENT != pv_q) ? 0 : gap_q + 1;
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   a_select_outs_off: assert property (o_STATE_SELECT |-> !o_FIRST_OUTPUT && !o_SECOND_OUTPUT)
      else $error("output active in method selection");
   a_select_halted: assert property (o_STATE_SELECT |-> o_PRESENT == 16'h0)
      else $error("count moved in method selection");
   a_method_clears: assert property (o_METHOD_WRITE |=> (o_SET1 | o_SET2 | o_PRESENT) == 16'h0)
      else $error("method change left values");
   a_method_in_select: assert property (o_METHOD_WRITE |-> o_STATE_SELECT)
      else $error("method written outside selection");
   // Factory restore out of a memory fault may legally drop the method back to forecast
   a_config_frozen: assert property (!I_SYS_RST [*3] ##0 $past(o_FAULT_CODE) == 2'h0 |-> $stable(o_METHOD_ABS) && $stable(o_MODE_A))
      else $error("configuration changed while powered");
   a_first_cause: assert property ($rose(o_FIRST_OUTPUT) |-> o_PRESENT >= t1)
      else $error("first output early");
   a_second_cause: assert property ($rose(o_SECOND_OUTPUT) |-> o_PRESENT >= s2)
      else $error("second output early");
   a_digit_bcd: assert property (o_SET1[3:0] <= 4'h9 && o_SET2[3:0] <= 4'h9)
      else $error("digit above nine");
   a_digit_wrap: assert property (o_SET1[3:0] == 4'h9 ##1 o_SET1[3:0] != 4'h9 |-> o_SET1[3:0] == 4'h0)
      else $error("digit did not wrap to zero");
   a_fault_outs_off: assert property (o_FAULT_CODE != 2'h0 |=> !o_FIRST_OUTPUT && !o_SECOND_OUTPUT)
      else $error("output active during fault");
   a_lamp_clears: assert property (o_RESET_LAMP && $past(o_RESET_LAMP) |-> o_PRESENT == 16'h0 && !o_SECOND_OUTPUT)
      else $error("count or output during reset");
   a_pv_step: assert property (o_PRESENT != pv_q && o_PRESENT != 16'h0 |-> o_PRESENT == pv_q + 16'h1)
      else $error("count stepped by other than one");
   // A clear to zero by the reset input may land anywhere between ticks
   a_tick_spacing: assert property (o_PRESENT != pv_q && pv_q != 16'h0 && o_PRESENT != 16'h0 |-> gap_q >= TICK_CYC - 1)
      else $error("count stepped too fast");
   c_select: cover property (o_STATE_SELECT);
   c_first: cover property ($rose(o_FIRST_OUTPUT));
   c_fault: cover property (o_FAULT_CODE == 2'h1);
endmodule : tstc_checker
bind tstc_top tstc_checker #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC), .TICK_CYC(TICK_CYC)) i_tstc_checker (
   .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .o_FIRST_OUTPUT(o_FIRST_OUTPUT), .o_SECOND_OUTPUT(o_SECOND_OUTPUT),
   .o_RESET_LAMP(o_RESET_LAMP), .o_FAULT_CODE(o_FAULT_CODE), .o_METHOD_ABS(o_METHOD_ABS),
   .o_METHOD_WRITE(o_METHOD_WRITE), .o_PRESENT(o_PRESENT), .o_SET1(o_SET1), .o_SET2(o_SET2),
   .o_MODE_A(o_MODE_A), .o_STATE_SELECT(o_STATE_SELECT));
`default_nettype wire

// [test/tstc_sensors.sv]
/*
 Far-side model: start sensor, two reset contacts and gate line.
 Assumes the bench changes requests at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tstc_sensors (
   input wire logic i_clk,
   input wire logic i_pnp,
   input wire logic i_start_on,
   input wire logic i_bounce,
   input wire logic [1:0] i_reset_on,
   input wire logic i_gate_on,
   output logic o_start,
   output logic o_reset_a,
   output logic o_reset_b,
   output logic o_gate
);
   logic on_q = 1'b0;
   logic [2:0] bounce_q = 3'h0;
   // A slow contact chatters for six cycles before it settles
   always_ff @(posedge i_clk) begin
      on_q <= i_start_on;
      if (i_bounce && i_start_on && !on_q) begin
         bounce_q <= 3'h6;
      end else if (bounce_q != 3'h0) begin
         bounce_q <= bounce_q - 3'h1;
      end
   end
   // Sourcing sensors drive the inverse level
   assign o_start = ((bounce_q != 3'h0) ? bounce_q[0] : i_start_on) ^ i_pnp;
   assign o_reset_a = i_reset_on[0] ^ i_pnp;
   assign o_reset_b = i_reset_on[1] ^ i_pnp;
   assign o_gate = i_gate_on ^ i_pnp;
endmodule : tstc_sensors
`default_nettype wire

// [test/tb.sv]
/*
 Self-checking bench for the timer core with shortened widths and tick.
 Assumes the sensor model on the start, reset and gate lines.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pnp = 1'b0, start_on = 1'b0, bounce = 1'b0, gate_on = 1'b0, stored = 1'b0, nv_valid = 1'b1;
   logic [1:0] reset_on = 2'h0, held = 2'h0;
   logic [7:1] sw = 7'h00;
   logic key_reset = 1'b0, set_sel = 1'b0, key_method = 1'b0, f_cpu = 1'b0, f_ram = 1'b0, f_nv = 1'b0;
   logic [3:0] key_digit = 4'h0;
   wire logic start, reset_a, reset_b, gate;
   logic first, second, lamp, cks, m_abs, m_new, m_wr, mode_a, pol, sel_st;
   logic [1:0] fcode, trange;
   logic [15:0] pv, set1, set2;
   int failures = 0, compares = 0, cycles = 0, k;
   always #50 clk = ~clk;
   tstc_sensors i_tstc_sensors (.i_clk(clk), .i_pnp(pnp), .i_start_on(start_on), .i_bounce(bounce),
      .i_reset_on(reset_on), .i_gate_on(gate_on), .o_start(start), .o_reset_a(reset_a),
      .o_reset_b(reset_b), .o_gate(gate));
   tstc_top #(.LONG_CYC(20), .SHORT_CYC(4), .TICK_CYC(5)) i_tstc_top (.I_CLK(clk), .I_SYS_RST(rst),
      .i_START(start), .i_RESET_A(reset_a), .i_RESET_B(reset_b), .i_GATE(gate), .i_SWITCH(sw),
      .i_KEY_RESET_HELD(held[1]), .i_KEY_DIGIT4_HELD(held[0]), .i_KEY_RESET(key_reset),
      .i_KEY_DIGIT(key_digit), .i_KEY_SET_SEL(set_sel), .i_KEY_METHOD(key_method),
      .i_METHOD_STORED(stored), .i_NV_VALID(nv_valid), .i_FAULT_CPU(f_cpu), .i_FAULT_RAM(f_ram),
      .i_FAULT_NV(f_nv), .o_FIRST_OUTPUT(first), .o_SECOND_OUTPUT(second), .o_RESET_LAMP(lamp),
      .o_FAULT_CODE(fcode), .o_CHECKSUM_IND(cks), .o_METHOD_ABS(m_abs), .o_METHOD_NEW(m_new),
      .o_METHOD_WRITE(m_wr), .o_PRESENT(pv), .o_SET1(set1), .o_SET2(set2), .o_TIME_RANGE(trange),
      .o_MODE_A(mode_a), .o_POLARITY_PNP(pol), .o_STATE_SELECT(sel_st));
   task automatic test_done;
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // Whole run needs under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic pwr(input logic [7:1] s, input logic st, input logic [1:0] h, input int n);
      sw = s;
      stored = st;
      held = h;
      rst = 1'b1;
      cyc(n);
      rst = 1'b0;
      cyc(3);
      held = 2'h0;
   endtask : pwr
   task automatic press(input logic [3:0] m, input int n);
      repeat (n) begin
         key_digit = m;
         cyc(1);
         key_digit = 4'h0;
         cyc(1);
      end
   endtask : press
   task automatic kr;
      key_reset = 1'b1;
      cyc(1);
      key_reset = 1'b0;
      cyc(3);
   endtask : kr
   // Bounded wait: 0 first output, 1 second output, 2 reset lamp
   task automatic wt(input int w);
      k = 0;
      while (k < 600 && (w == 0 ? first : (w == 1 ? second : lamp)) !== 1'b1) begin
         cyc(1);
         k++;
      end
   endtask : wt
   initial begin
      pwr(7'h00, 1'b0, 2'h0, 16);
      chk({13'h0, m_abs, mode_a, sel_st}, 16'h0);
      sw = 7'h04;
      cyc(2);
      chk(16'(mode_a), 16'h0);
      press(4'h1, 12);
      chk(set1, 16'h0002);
      set_sel = 1'b1;
      press(4'h1, 5);
      press(4'h2, 1);
      chk(set2, 16'h0015);
      start_on = 1'b1;
      wt(0);
      chk({pv[13:0], first, second}, {14'h000D, 2'b10});
      wt(1);
      chk(pv, 16'h000F);
      for (int t = 0; t < 2; t++) begin
         start_on = 1'b0;
         cyc(25);
         start_on = 1'b1;
         cyc(60);
         chk(16'(pv > 16'h0), 16'h1);
         reset_on[t] = 1'b1;
         wt(2);
         cyc(2);
         chk({pv[13:0], first, second}, 16'h0);
         start_on = 1'b0;
         reset_on = 2'h0;
         cyc(25);
      end
      start_on = 1'b1;
      cyc(3);
      start_on = 1'b0;
      cyc(40);
      chk(pv, 16'h0);
      set_sel = 1'b0;
      press(4'h2, 2);
      bounce = 1'b1;
      start_on = 1'b1;
      wt(0);
      chk(16'(pv < 16'h2), 16'h1);
      f_cpu = 1'b1;
      cyc(3);
      chk({12'h0, fcode, first, second}, 16'h4);
      chk(set1, 16'h0022);
      f_cpu = 1'b0;
      kr();
      chk(16'(fcode), 16'h0);
      f_nv = 1'b1;
      cyc(3);
      chk({13'h0, fcode, cks}, 16'h5);
      f_nv = 1'b0;
      kr();
      chk(set1 | set2, 16'h0);
      f_ram = 1'b1;
      cyc(3);
      chk({12'h0, fcode, first, second}, 16'h8);
      f_ram = 1'b0;
      kr();
      chk(16'(fcode), 16'h2);
      start_on = 1'b0;
      bounce = 1'b0;
      pnp = 1'b1;
      pwr(7'h1C, 1'b1, 2'h0, 4);
      chk({12'h0, fcode, m_abs, mode_a, pol}, 16'h7);
      press(4'h1, 3);
      set_sel = 1'b1;
      press(4'h1, 6);
      start_on = 1'b1;
      wt(0);
      chk(pv, 16'h0003);
      wt(1);
      chk(pv, 16'h0006);
      gate_on = 1'b1;
      cyc(10);
      k = pv;
      cyc(30);
      chk(pv, 16'(k));
      gate_on = 1'b0;
      cyc(20);
      chk(16'(pv > 16'(k)), 16'h1);
      start_on = 1'b0;
      pnp = 1'b0;
      pwr(7'h00, 1'b0, 2'h3, 4);
      chk({14'h0, sel_st, m_abs}, 16'h2);
      start_on = 1'b1;
      cyc(40);
      chk({pv[13:0], first, second}, 16'h0);
      key_method = 1'b1;
      cyc(1);
      key_method = 1'b0;
      cyc(2);
      chk({14'h0, m_new, sel_st}, 16'h3);
      chk(set1 | set2 | pv, 16'h0);
      start_on = 1'b0;
      pwr(7'h43, 1'b0, 2'h1, 4);
      chk(16'(sel_st), 16'h0);
      chk(16'(trange), 16'h3);
      press(4'h1, 1);
      chk(set1, 16'h0000);
      test_done();
   end
endmodule : tb
`default_nettype wire
